// *** rtl/mcr_regs.vh ***
// Constants for the metering command and configuration register block
`ifndef MCR_REGS_VH
`define MCR_REGS_VH

// ==========================================================================
// Command byte layout
`define MCR_CMD_WIDTH        8
`define MCR_CMD_ADDR_MSB     5
`define MCR_CMD_ADDR_LSB     0
`define MCR_CMD_DIR_BIT      7
`define MCR_CMD_LAST_BIT     5'h0007

// ==========================================================================
// Register addresses and widths
`define MCR_ADDR_WIDTH       6
`define MCR_ADDR_CONFIG      6'h09
`define MCR_CONFIG_WIDTH     5'h0010
`define MCR_OTHER_WIDTH      5'h0008
`define MCR_SHIFT_WIDTH      16

// ==========================================================================
// Configuration register fields
`define MCR_CONFIG_RESET     16'h000c
`define MCR_CONFIG_IMPL_MASK 16'h1fff
`define MCR_BIT_HPF_BYPASS   0
`define MCR_BIT_LPF_BYPASS   1
`define MCR_BIT_PULSE_OFF    2
`define MCR_BIT_DIP_OFF      3
`define MCR_BIT_POWERDOWN    4
`define MCR_BIT_THERMAL_GO   5
`define MCR_BIT_SOFT_RESET   6
`define MCR_BIT_LINECYCLE    7
`define MCR_BIT_CUR_SHORT    8
`define MCR_BIT_VOLT_SHORT   9
`define MCR_BIT_SWAP         10
`define MCR_RATE_LSB         11
`define MCR_RATE_MSB         12

// ==========================================================================
// Waveform rate divider masks, codes 00..11
`define MCR_RATE_MASK_128    10'h007f
`define MCR_RATE_MASK_256    10'h00ff
`define MCR_RATE_MASK_512    10'h01ff
`define MCR_RATE_MASK_1024   10'h03ff
`define MCR_RATE_CNT_WIDTH   10

// ==========================================================================
// Timing
`define MCR_CLK_PERIOD_PS    8000
`define MCR_SOFT_RESET_US    18
// Quiet time rounded up to whole cycles, sized to the hold counter
`define MCR_SOFT_RESET_CYC   12'h08ca
`define MCR_HOLD_CNT_WIDTH   12

`endif

// *** rtl/mcr_serial_pins.v ***
// Pin synchroniser and clock edge detector for the serial port
`timescale 1ns/1ps
`default_nettype none

module mcr_serial_pins (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst,
  // Raw pins
  input  wire serialClkPin,
  input  wire selectPinN,
  input  wire dataInPin,
  // Synchronised view
  output reg  clkRise,
  output reg  clkFall,
  output wire selected,
  output wire dataBit
);

  // ==========================================================================
  // Two-stage synchronisers, first stage read only by the second
  reg [2:0] meta_q;
  reg [2:0] sync_q;
  reg       clkLast_q;

  always @(posedge clk_sys) begin
    if (rst) begin
      meta_q    <= 3'h7;
      sync_q    <= 3'h7;
      clkLast_q <= 1'b1;
      clkRise   <= 1'b0;
      clkFall   <= 1'b0;
    end else begin
      meta_q    <= {serialClkPin, selectPinN, dataInPin};
      sync_q    <= meta_q;
      clkLast_q <= sync_q[2];
      // Edges count only while selected so idle clock noise is ignored
      clkRise   <= sync_q[2] & ~clkLast_q & ~sync_q[1];
      clkFall   <= ~sync_q[2] & clkLast_q & ~sync_q[1];
    end
  end

  // ==========================================================================
  // Data delayed one cycle to line up with the registered edge strobes
  reg dataDly_q;
  reg selDly_q;

  always @(posedge clk_sys) begin
    if (rst) begin
      dataDly_q <= 1'b0;
      selDly_q  <= 1'b0;
    end else begin
      dataDly_q <= sync_q[0];
      selDly_q  <= ~sync_q[1];
    end
  end

  assign dataBit  = dataDly_q;
  assign selected = selDly_q;

endmodule

`default_nettype wire

// *** rtl/mcr_rate_divider.v ***
// Waveform sample strobe generator with selectable division
`timescale 1ns/1ps
`default_nettype none
`include "mcr_regs.vh"

module mcr_rate_divider (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // Rate code
  input  wire [1:0] rateCode,
  // Strobe out
  output reg        sampleStrobe
);

  reg [`MCR_RATE_CNT_WIDTH-1:0] count_q;
  reg [`MCR_RATE_CNT_WIDTH-1:0] mask;

  always @* begin
    case (rateCode)
      2'h0:    mask = `MCR_RATE_MASK_128;
      2'h1:    mask = `MCR_RATE_MASK_256;
      2'h2:    mask = `MCR_RATE_MASK_512;
      default: mask = `MCR_RATE_MASK_1024;
    endcase
  end

  // ==========================================================================
  // Free counter; a rate change takes effect at the next mask match
  always @(posedge clk_sys) begin
    if (rst) begin
      count_q      <= {`MCR_RATE_CNT_WIDTH{1'b0}};
      sampleStrobe <= 1'b0;
    end else begin
      count_q      <= count_q + 1'b1;
      sampleStrobe <= ((count_q & mask) == mask);
    end
  end

endmodule

`default_nettype wire

// *** rtl/mcr_comm_mode_regs.v ***
// Serial command front end and operating configuration register
//
// Notes on behaviour
// - Command byte first, then one data transfer
// - Command register eight bits, write only
// - Command bits 0-5 address the target
// - Command bit 7: one write, zero read
// - Config bit 0 bypasses current highpass
// - Config bit 1 bypasses post-multiplier lowpass
// - Config bit 2 stops pulse output, resets one
// - Config bit 3 disables dip detect, resets one
// - Config bit 4 powers down both converters
// - Config bit 5 starts thermal conversion, self-clears
// - Config bit 6 soft reset, 18 us quiet
// - Config bit 7 selects line-cycle accumulation
// - Config bits 8,9 short current, voltage inputs
// - Config bit 10 swaps channel routing
// - Config bits 12:11 pick waveform rate divider
`timescale 1ns/1ps
`default_nettype none
`include "mcr_regs.vh"

module mcr_comm_mode_regs (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Serial pins
  input  wire        serialClkPin,
  input  wire        selectPinN,
  input  wire        dataInPin,
  output reg         dataOutPin,
  output reg         dataOutEn,
  // Thermal conversion handshake
  input  wire        thermalDone,
  output reg         thermalStart,
  // Soft reset
  output reg         softResetPulse,
  output wire        softResetBusy,
  // Configuration outputs
  output wire        current_highpass_bypass,
  output wire        power_lowpass_bypass,
  output wire        pulse_output_off,
  output wire        dip_detect_off,
  output wire        converters_powerdown,
  output wire        thermal_conversion_go,
  output wire        linecycle_accumulate_mode,
  output wire        current_input_short,
  output wire        voltage_input_short,
  output wire        channel_swap,
  output wire [1:0]  waveform_rate_select,
  output wire        waveformSampleStrobe
);

  // ==========================================================================
  // Local decode helpers
  function [4:0] regWidth;
    input [`MCR_ADDR_WIDTH-1:0] addr;
    begin
      if (addr == `MCR_ADDR_CONFIG) begin
        regWidth = `MCR_CONFIG_WIDTH;
      end else begin
        regWidth = `MCR_OTHER_WIDTH;
      end
    end
  endfunction

  function isConfig;
    input [`MCR_ADDR_WIDTH-1:0] addr;
    begin
      isConfig = (addr == `MCR_ADDR_CONFIG);
    end
  endfunction

  localparam ST_COMMAND = 1'b0;
  localparam ST_DATA    = 1'b1;

  // ==========================================================================
  // Pin front end
  wire clkRise;
  wire clkFall;
  wire selected;
  wire dataBit;

  mcr_serial_pins uPins (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .serialClkPin (serialClkPin),
    .selectPinN   (selectPinN),
    .dataInPin    (dataInPin),
    .clkRise      (clkRise),
    .clkFall      (clkFall),
    .selected     (selected),
    .dataBit      (dataBit)
  );

  // ==========================================================================
  // Soft reset hold-off counter
  reg [`MCR_HOLD_CNT_WIDTH-1:0] hold_q;
  reg [`MCR_HOLD_CNT_WIDTH-1:0] hold_d;
  wire                          holdActive;

  assign holdActive    = (hold_q != {`MCR_HOLD_CNT_WIDTH{1'b0}});
  assign softResetBusy = holdActive;

  // ==========================================================================
  // Transfer state
  reg                         state_q;
  reg                         state_d;
  reg [4:0]                   bitCnt_q;
  reg [4:0]                   bitCnt_d;
  reg [`MCR_SHIFT_WIDTH-1:0]  shiftIn_q;
  reg [`MCR_SHIFT_WIDTH-1:0]  shiftIn_d;
  reg [`MCR_SHIFT_WIDTH-1:0]  shiftOut_q;
  reg [`MCR_SHIFT_WIDTH-1:0]  shiftOut_d;
  reg [`MCR_ADDR_WIDTH-1:0]   target_register_index_q;
  reg [`MCR_ADDR_WIDTH-1:0]   target_register_index_d;
  reg                         writeDir_q;
  reg                         writeDir_d;
  reg [4:0]                   width_q;
  reg [4:0]                   width_d;
  reg                         doutBit_d;
  reg                         doutEn_d;

  // ==========================================================================
  // Configuration register
  reg  [`MCR_SHIFT_WIDTH-1:0] config_q;
  reg  [`MCR_SHIFT_WIDTH-1:0] config_d;
  reg                         configWrite;
  reg                         thermalStart_d;
  reg                         softReset_d;
  wire [`MCR_SHIFT_WIDTH-1:0] newByte;
  wire [`MCR_SHIFT_WIDTH-1:0] readValue;
  wire [`MCR_SHIFT_WIDTH-1:0] writeValue;

  assign newByte = {shiftIn_q[`MCR_SHIFT_WIDTH-2:0], dataBit};

  // Bit 6 always reads back its reset value, it only fires a pulse
  assign readValue = config_q & `MCR_CONFIG_IMPL_MASK;

  // Undocumented positions keep their reset value on write
  assign writeValue = (newByte & `MCR_CONFIG_IMPL_MASK)
                    | (`MCR_CONFIG_RESET & ~`MCR_CONFIG_IMPL_MASK);

  // ==========================================================================
  // Command and data sequencer
  always @* begin
    state_d                 = state_q;
    bitCnt_d                = bitCnt_q;
    shiftIn_d               = shiftIn_q;
    shiftOut_d              = shiftOut_q;
    target_register_index_d = target_register_index_q;
    writeDir_d              = writeDir_q;
    width_d                 = width_q;
    doutBit_d               = dataOutPin;
    doutEn_d                = dataOutEn;
    configWrite             = 1'b0;
    if (!selected || holdActive) begin
      // Deselect or soft reset quiet time abandons any half transfer
      state_d  = ST_COMMAND;
      bitCnt_d = 5'h00;
      doutEn_d = 1'b0;
    end else begin
      case (state_q)
        ST_COMMAND: begin
          if (clkRise) begin
            shiftIn_d = newByte;
            bitCnt_d  = bitCnt_q + 5'h01;
            if (bitCnt_q == `MCR_CMD_LAST_BIT) begin
              // Command byte never reads back, it only steers the next phase
              target_register_index_d = newByte[`MCR_CMD_ADDR_MSB:`MCR_CMD_ADDR_LSB];
              writeDir_d              = newByte[`MCR_CMD_DIR_BIT];
              width_d                 = regWidth(newByte[`MCR_CMD_ADDR_MSB:`MCR_CMD_ADDR_LSB]);
              bitCnt_d                = 5'h00;
              state_d                 = ST_DATA;
              if (!newByte[`MCR_CMD_DIR_BIT]) begin
                // Reads left-aligned so the first bit is the register MSB
                if (isConfig(newByte[`MCR_CMD_ADDR_MSB:`MCR_CMD_ADDR_LSB])) begin
                  shiftOut_d = readValue;
                end else begin
                  shiftOut_d = {`MCR_SHIFT_WIDTH{1'b0}};
                end
                doutEn_d = 1'b1;
              end
            end
          end
        end
        ST_DATA: begin
          if (clkFall && !writeDir_q) begin
            doutBit_d  = shiftOut_q[`MCR_SHIFT_WIDTH-1];
            shiftOut_d = {shiftOut_q[`MCR_SHIFT_WIDTH-2:0], 1'b0};
          end
          if (clkRise) begin
            shiftIn_d = newByte;
            bitCnt_d  = bitCnt_q + 5'h01;
            if (bitCnt_q == width_q - 5'h01) begin
              // Exactly one register width, then back to command wait
              state_d  = ST_COMMAND;
              bitCnt_d = 5'h00;
              doutEn_d = 1'b0;
              if (writeDir_q && isConfig(target_register_index_q)) begin
                configWrite = 1'b1;
              end
            end
          end
        end
        default: begin
          state_d  = ST_COMMAND;
          bitCnt_d = 5'h00;
          doutEn_d = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Configuration update, thermal self-clear and soft reset
  always @* begin
    config_d       = config_q;
    thermalStart_d = 1'b0;
    softReset_d    = 1'b0;
    hold_d         = holdActive ? hold_q - 1'b1 : hold_q;
    if (thermalDone) begin
      config_d[`MCR_BIT_THERMAL_GO] = 1'b0;
    end
    if (configWrite) begin
      if (writeValue[`MCR_BIT_SOFT_RESET]) begin
        // Whole register returns to defaults; host must stay quiet
        config_d    = `MCR_CONFIG_RESET;
        softReset_d = 1'b1;
        hold_d      = `MCR_SOFT_RESET_CYC;
      end else begin
        config_d = writeValue;
        // A fresh start wins over a completion in the same cycle
        thermalStart_d = writeValue[`MCR_BIT_THERMAL_GO];
        if (thermalDone && !writeValue[`MCR_BIT_THERMAL_GO]) begin
          config_d[`MCR_BIT_THERMAL_GO] = 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Registers
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q                 <= ST_COMMAND;
      bitCnt_q                <= 5'h00;
      shiftIn_q               <= 16'h0000;
      shiftOut_q              <= 16'h0000;
      target_register_index_q <= 6'h00;
      writeDir_q              <= 1'b0;
      width_q                 <= `MCR_OTHER_WIDTH;
      dataOutPin              <= 1'b0;
      dataOutEn               <= 1'b0;
      config_q                <= `MCR_CONFIG_RESET;
      thermalStart            <= 1'b0;
      softResetPulse          <= 1'b0;
      hold_q                  <= {`MCR_HOLD_CNT_WIDTH{1'b0}};
    end else begin
      state_q                 <= state_d;
      bitCnt_q                <= bitCnt_d;
      shiftIn_q               <= shiftIn_d;
      shiftOut_q              <= shiftOut_d;
      target_register_index_q <= target_register_index_d;
      writeDir_q              <= writeDir_d;
      width_q                 <= width_d;
      dataOutPin              <= doutBit_d;
      dataOutEn               <= doutEn_d;
      config_q                <= config_d;
      thermalStart            <= thermalStart_d;
      softResetPulse          <= softReset_d;
      hold_q                  <= hold_d;
    end
  end

  // ==========================================================================
  // Configuration fields out
  assign current_highpass_bypass   = config_q[`MCR_BIT_HPF_BYPASS];
  assign power_lowpass_bypass      = config_q[`MCR_BIT_LPF_BYPASS];
  assign pulse_output_off          = config_q[`MCR_BIT_PULSE_OFF];
  assign dip_detect_off            = config_q[`MCR_BIT_DIP_OFF];
  assign converters_powerdown      = config_q[`MCR_BIT_POWERDOWN];
  assign thermal_conversion_go     = config_q[`MCR_BIT_THERMAL_GO];
  assign linecycle_accumulate_mode = config_q[`MCR_BIT_LINECYCLE];
  assign current_input_short       = config_q[`MCR_BIT_CUR_SHORT];
  assign voltage_input_short       = config_q[`MCR_BIT_VOLT_SHORT];
  assign channel_swap              = config_q[`MCR_BIT_SWAP];
  assign waveform_rate_select      = config_q[`MCR_RATE_MSB:`MCR_RATE_LSB];

  // ==========================================================================
  // Waveform sample strobe
  mcr_rate_divider uRate (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .rateCode     (config_q[`MCR_RATE_MSB:`MCR_RATE_LSB]),
    .sampleStrobe (waveformSampleStrobe)
  );

endmodule

`default_nettype wire

// *** bench/mcr_host_model.sv ***
// Host side serial port model driving command and data frames
`timescale 1ns/1ps
`default_nettype none

module mcr_host_model (
  // Clock
  input  wire logic clk_sys,
  // Serial port
  input  wire logic dataOutPin,
  input  wire logic dataOutEn,
  output var  logic serialClkPin,
  output var  logic selectPinN,
  output var  logic dataInPin
);
  // Six-cycle phases stay clear of the four-cycle minimum
  localparam int PH = 6;

  initial begin
    serialClkPin = 1'b1;
    selectPinN   = 1'b1;
    dataInPin    = 1'b0;
  end

  // ==========================================================
  // Command byte then nb data bits, MSB first, drive on fall
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nb, output logic [15:0] rdv);
    logic [23:0] sh;
    int          i;
    sh  = {cmd, wd << (16 - nb)};
    rdv = 16'h0000;
    @(posedge clk_sys);
    #1;
    selectPinN = 1'b0;
    for (i = 0; i < 8 + nb; i++) begin
      repeat (PH) @(posedge clk_sys);
      #1;
      serialClkPin = 1'b0;
      // Data line toggles while released, so stale bits never pass
      dataInPin = (i < 8 || cmd[7]) ? sh[23 - i] : ~dataInPin;
      repeat (PH) @(posedge clk_sys);
      #1;
      // Released line reads inverted so a missing enable shows up
      if (i >= 8) rdv = {rdv[14:0], dataOutEn ? dataOutPin : ~dataOutPin};
      serialClkPin = 1'b1;
    end
    repeat (PH) @(posedge clk_sys);
    #1;
    selectPinN = 1'b1;
    dataInPin  = ~dataInPin;
  endtask
endmodule
`default_nettype wire

// *** bench/mcr_comm_mode_regs_props.sv ***
// Checker for the command front end and configuration register
`timescale 1ns/1ps
`default_nettype none

module mcr_comm_mode_regs_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Watched ports
  input wire logic       selectPinN,
  input wire logic       dataOutEn,
  input wire logic       thermalDone,
  input wire logic       thermalStart,
  input wire logic       softResetPulse,
  input wire logic       softResetBusy,
  input wire logic       current_highpass_bypass,
  input wire logic       pulse_output_off,
  input wire logic       dip_detect_off,
  input wire logic       converters_powerdown,
  input wire logic       thermal_conversion_go,
  input wire logic [1:0] waveform_rate_select,
  input wire logic       waveformSampleStrobe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================================
  // Busy length counter
  logic [11:0] busyCnt_q;
  always_ff @(posedge clk_sys) begin
    busyCnt_q <= (rst || !softResetBusy) ? 12'h0000 : busyCnt_q + 12'h0001;
  end

  chk_reset_dflt: assert property (disable iff (1'b0) rst |=> pulse_output_off && dip_detect_off
    && !converters_powerdown && !softResetBusy) else $error("reset defaults wrong");
  chk_oe_deselect: assert property (selectPinN [*6] |-> !dataOutEn)
    else $error("data out driven while deselected");
  chk_oe_busy: assert property (softResetBusy |-> !dataOutEn) else $error("data out during soft reset");
  chk_start_sets: assert property (thermalStart |-> ##[0:2] thermal_conversion_go)
    else $error("thermal bit not set");
  chk_start_single: assert property (thermalStart |=> !thermalStart) else $error("start pulse too long");
  chk_done_clears: assert property ($rose(thermalDone) && !thermalStart |-> ##[1:3] !thermal_conversion_go)
    else $error("thermal bit not cleared");
  chk_soft_busy: assert property (softResetPulse |=> softResetBusy [*8]) else $error("busy not raised");
  chk_busy_len: assert property ($fell(softResetBusy) |-> busyCnt_q >= 12'h08c9 && busyCnt_q <= 12'h08cb)
    else $error("busy length wrong");
  chk_soft_dflt: assert property (softResetPulse |-> ##[0:2] (pulse_output_off && dip_detect_off
    && !current_highpass_bypass && waveform_rate_select == 2'b00)) else $error("soft reset defaults wrong");
  chk_strobe_gap: assert property (waveformSampleStrobe |=> !waveformSampleStrobe [*8])
    else $error("strobe too close");
  chk_idle_stable: assert property ((selectPinN && !softResetPulse) [*8] |->
    $stable({current_highpass_bypass, converters_powerdown, waveform_rate_select})) else $error("config changed idle");
endmodule

bind mcr_comm_mode_regs mcr_comm_mode_regs_chk CHK (.clk_sys, .rst, .selectPinN, .dataOutEn, .thermalDone,
  .thermalStart, .softResetPulse, .softResetBusy, .current_highpass_bypass, .pulse_output_off, .dip_detect_off,
  .converters_powerdown, .thermal_conversion_go, .waveform_rate_select, .waveformSampleStrobe);
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the command front end and configuration register
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       thermalDone = 1'b0;
  logic       sClk, selN, dIn, dOut, dOutEn, tStart, sPulse, sBusy, strobe;
  logic       hpf, lpf, pOff, dOff, pDown, tGo, lCyc, iSh, vSh, swp;
  logic [1:0] rate;
  int         error_cnt = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         nStart = 0;
  int         nSoft = 0;
  int         seed = 32'h663f;
  int         cfgModel;

  always #4 clk_sys = ~clk_sys;

  mcr_comm_mode_regs DUT (.clk_sys(clk_sys), .rst(rst), .serialClkPin(sClk), .selectPinN(selN),
    .dataInPin(dIn), .dataOutPin(dOut), .dataOutEn(dOutEn), .thermalDone(thermalDone), .thermalStart(tStart),
    .softResetPulse(sPulse), .softResetBusy(sBusy), .current_highpass_bypass(hpf), .power_lowpass_bypass(lpf),
    .pulse_output_off(pOff), .dip_detect_off(dOff), .converters_powerdown(pDown), .thermal_conversion_go(tGo),
    .linecycle_accumulate_mode(lCyc), .current_input_short(iSh), .voltage_input_short(vSh), .channel_swap(swp),
    .waveform_rate_select(rate), .waveformSampleStrobe(strobe));

  mcr_host_model HOST (.clk_sys(clk_sys), .dataOutPin(dOut), .dataOutEn(dOutEn), .serialClkPin(sClk),
    .selectPinN(selN), .dataInPin(dIn));

  // ==========================================================
  // Helpers
  function automatic logic [15:0] outs();
    return {3'b000, rate, swp, vSh, iSh, lCyc, 1'b0, tGo, pDown, dOff, pOff, lpf, hpf};
  endfunction

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (exp !== got) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrReg(input logic [5:0] a, input int nb, input logic [15:0] d);
    logic [15:0] x;
    HOST.xfer({2'b10, a}, d, nb, x);
  endtask

  task automatic rdReg(input logic [5:0] a, input int nb, output logic [15:0] d);
    HOST.xfer({2'b00, a}, 16'h0000, nb, d);
  endtask

  task automatic waitStrobe(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (strobe !== 1'b1 && n < 2000);
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Pulse counters and hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (tStart === 1'b1) nStart++;
    if (sPulse === 1'b1) nSoft++;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] d;
    int          c;
    int          n;
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    cfgModel = 16'h000c;
    chk("reset outs", cfgModel[15:0], outs());
    rdReg(6'h09, 16, d);
    chk("reset read", cfgModel[15:0], d);
    for (c = 0; c < 6; c++) begin
      d = $random(seed) & 16'hff9f;
      wrReg(6'h09, 16, d);
      cfgModel = d & 16'h1fbf;
      chk("outs", cfgModel[15:0], outs());
      rdReg(6'h09, 16, d);
      chk("readback", cfgModel[15:0], d);
    end
    wrReg(6'h0a, 8, 16'h00ff);
    chk("other write", cfgModel[15:0], outs());
    rdReg(6'h0a, 8, d);
    chk("other read", 16'h0000, d);
    // Cut frame after half the data: must be dropped
    HOST.xfer(8'h89, 16'h00ff, 8, d);
    chk("abort write", cfgModel[15:0], outs());
    for (c = 0; c < 4; c++) begin
      cfgModel = (cfgModel & 16'h07ff) | (c << 11);
      wrReg(6'h09, 16, cfgModel[15:0]);
      waitStrobe(n);
      waitStrobe(n);
      chk("strobe period", 16'(128 << c), 16'(n));
    end
    n = nStart;
    wrReg(6'h09, 16, cfgModel[15:0] | 16'h0020);
    chk("start pulse", 16'(n + 1), 16'(nStart));
    chk("go set", 16'h0001, {15'h0000, tGo});
    @(posedge clk_sys);
    #1;
    thermalDone = 1'b1;
    @(posedge clk_sys);
    #1;
    thermalDone = 1'b0;
    repeat (4) @(posedge clk_sys);
    rdReg(6'h09, 16, d);
    chk("go cleared", cfgModel[15:0], d);
    n = nSoft;
    wrReg(6'h09, 16, cfgModel[15:0] | 16'h0040);
    cfgModel = 16'h000c;
    chk("soft pulse", 16'(n + 1), 16'(nSoft));
    chk("soft busy", 16'h0001, {15'h0000, sBusy});
    chk("soft dflt", cfgModel[15:0], outs());
    // Deliberately early transfer: must be ignored
    wrReg(6'h09, 16, 16'h1fbf);
    chk("busy refuse", cfgModel[15:0], outs());
    n = 0;
    while (sBusy !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("busy end", 16'h0000, {15'h0000, sBusy});
    rdReg(6'h09, 16, d);
    chk("after soft", cfgModel[15:0], d);
    wrReg(6'h09, 16, 16'h0713);
    chk("pre reset", 16'h0713, outs());
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("second reset", cfgModel[15:0], outs());
    repeat (3) @(posedge clk_sys);
    rdReg(6'h09, 16, d);
    chk("read after reset", cfgModel[15:0], d);
    wrap_up();
  end
endmodule
`default_nettype wire
